//--- src/ddrmb_core.sv
// ddr module command, mode register, burst and presence-detect logic
// assumes controller logic on core_clk_i; i2c pins are asynchronous
// How it works
// [RL1] commands sampled only at rising clock edge
// [RL2] write pairs captured; read pairs launched
// [RL3] read strobe toggles only with read data
// [RL4] each beat moves two words at once
// [RL5] controller activates row before read/write
// [RL6] activate stores bank and row address
// [RL7] read/write takes bank and start column
// [RL8] burst lengths two, four, eight supported
// [RL9] auto precharge closes row after burst
// [RL10] four banks open and close independently
// [RL11] store 256 bytes, upper half for customer
// [RL12] i2c target, three straps pick address
// [RL13] write protect off, writes always accepted
// [RL14] mode set with bank zero loads register
// [RL15] dll reset bit clears itself
// [RL16] mode load never touches the array
// [RL17] controller loads mode only when idle
// [RL18] length, type, latency, mode field layout
// [RL19] type bit selects sequential or interleaved
// [RL20] burst never exceeds programmed length
// [RL21] low column bits give start in block
// [RL22] burst wraps inside its aligned block
// [RL23] controller avoids reserved mode encodings
// [RL24] sequential adds, interleaved xors index
// [RL25] read latency two or two and half
// [RL26] column block top bit nine
// [RL27] mode fields apply to later bursts
`timescale 1ns/1ns
`default_nettype none
module ddrmb_core #(
    parameter int DW = 64,
    parameter int AW = 13,
    parameter int CW = 10,
    parameter int RKEEP = 2,
    parameter int FDEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [1:0] ba_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic wr_valid_i,
    input wire logic [DW-1:0] wr_rise_i,
    input wire logic [DW-1:0] wr_fall_i,
    input wire logic rd_ready_i,
    output logic rd_valid_o,
    output logic [DW-1:0] rd_rise_o,
    output logic [DW-1:0] rd_fall_o,
    output logic rd_strobe_o,
    output logic [AW-1:0] mode_o,
    output logic [3:0] bank_open_o,
    output logic burst_busy_o,
    input wire logic [2:0] presence_addr_straps_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    localparam int MW = 2 + RKEEP + CW;

    logic [2:0] cmd;
    logic cmd_ok, act_go, pre_go, mrs_go, rd_go, wr_go, idle;
    logic [AW-1:0] mode;
    logic [2:0] bl_code, cl_code, bl_mask;
    logic [1:0] lat_load;
    logic bank_open [ddrmb_pkg::NBANK];
    logic [AW-1:0] brow [ddrmb_pkg::NBANK];
    ddrmb_pkg::ddrmb_bst_t bst;
    logic busy, b_intl, b_ap, step, burst_end, mem_we;
    logic [1:0] beat, b_last, lat_cnt, b_bank;
    logic [2:0] b_mask;
    logic [CW-1:0] b_col, c0, c1;
    logic [RKEEP-1:0] b_row;
    logic [MW-1:0] idx0, idx1;
    logic [DW-1:0] mem [2**MW];
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [2*DW-1:0] f_in_data, f_out_data;

    function automatic logic [2:0] ofs(input logic [2:0] s, input logic [2:0] j, input logic [2:0] m,
                                       input logic il);
        ofs = il ? ((s ^ j) & m) : ((s + j) & m);
    endfunction : ofs

    // command decode
    assign cmd = {ras_n_i, cas_n_i, we_n_i};
    assign cmd_ok = !cs_n_i; // RL1
    assign idle = bst == ddrmb_pkg::B_IDLE;
    assign act_go = cmd_ok && cmd == ddrmb_pkg::CMD_ACT;
    assign pre_go = cmd_ok && cmd == ddrmb_pkg::CMD_PRE;
    assign mrs_go = cmd_ok && cmd == ddrmb_pkg::CMD_MRS && ba_i == 2'h0; // RL14
    assign rd_go = cmd_ok && cmd == ddrmb_pkg::CMD_RD && idle && bank_open[ba_i] && bl_mask != 3'h0; // RL5
    assign wr_go = cmd_ok && cmd == ddrmb_pkg::CMD_WR && idle && bank_open[ba_i] && bl_mask != 3'h0; // RL5

    // mode register fields
    assign bl_code = mode[ddrmb_pkg::MR_BL_LSB +: 3]; // RL18
    assign cl_code = mode[ddrmb_pkg::MR_CL_LSB +: 3]; // RL18

    always_comb
    begin
        case (bl_code)
            ddrmb_pkg::BL_2: bl_mask = ddrmb_pkg::MASK_2; // RL8
            ddrmb_pkg::BL_4: bl_mask = ddrmb_pkg::MASK_4; // RL8
            ddrmb_pkg::BL_8: bl_mask = ddrmb_pkg::MASK_8; // RL8
            default: bl_mask = 3'h0;
        endcase
    end

    always_comb
    begin
        case (cl_code)
            ddrmb_pkg::CL_2: lat_load = 2'(ddrmb_pkg::CL2_CYC - 2); // RL25
            default: lat_load = 2'(ddrmb_pkg::CL25_CYC - 2); // RL25
        endcase
    end

    // mode register; dll reset bit lives one cycle
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            mode <= ddrmb_pkg::MR_RESET;
        else if (mrs_go)
            mode <= addr_i; // RL14
        else
            mode[ddrmb_pkg::MR_DLL_BIT] <= 1'b0; // RL15
    end
    assign mode_o = mode;

    // per-bank open row state
    for (genvar g = 0; g < ddrmb_pkg::NBANK; g++)
    begin : g_bank
        always_ff @(posedge core_clk_i)
        begin
            if (sys_rst_i)
            begin
                bank_open[g] <= 1'b0;
                brow[g] <= '0;
            end
            else if (act_go && ba_i == 2'(g))
            begin
                bank_open[g] <= 1'b1; // RL10
                brow[g] <= addr_i; // RL6
            end
            else if (pre_go && (ba_i == 2'(g) || addr_i[ddrmb_pkg::AP_BIT]))
                bank_open[g] <= 1'b0; // RL10
            else if (burst_end && b_ap && b_bank == 2'(g))
                bank_open[g] <= 1'b0; // RL9
        end
        assign bank_open_o[g] = bank_open[g];
    end

    // burst engine
    assign step = (bst == ddrmb_pkg::B_RD && f_in_ready) || (bst == ddrmb_pkg::B_WR && wr_valid_i); // RL4
    assign burst_end = step && beat == b_last; // RL20

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            bst <= ddrmb_pkg::B_IDLE;
            busy <= 1'b0;
            beat <= 2'h0;
            lat_cnt <= 2'h0;
            b_bank <= 2'h0;
            b_col <= '0;
            b_row <= '0;
            b_mask <= 3'h0;
            b_last <= 2'h0;
            b_intl <= 1'b0;
            b_ap <= 1'b0;
        end
        else
        begin
            case (bst)
                ddrmb_pkg::B_IDLE:
                begin
                    if (rd_go || wr_go)
                    begin
                        bst <= rd_go ? ddrmb_pkg::B_LAT : ddrmb_pkg::B_WR;
                        busy <= 1'b1;
                        beat <= 2'h0;
                        lat_cnt <= lat_load; // RL25
                        b_bank <= ba_i; // RL7
                        b_col <= addr_i[CW-1:0]; // RL7
                        b_row <= brow[ba_i][RKEEP-1:0];
                        b_mask <= bl_mask; // RL27
                        b_last <= bl_mask[2:1]; // RL20
                        b_intl <= mode[ddrmb_pkg::MR_BT_BIT]; // RL19
                        b_ap <= addr_i[ddrmb_pkg::AP_BIT]; // RL9
                    end
                end
                ddrmb_pkg::B_LAT:
                begin
                    if (lat_cnt == 2'h0)
                        bst <= ddrmb_pkg::B_RD;
                    else
                        lat_cnt <= lat_cnt - 2'h1;
                end
                ddrmb_pkg::B_RD, ddrmb_pkg::B_WR:
                begin
                    if (burst_end)
                    begin
                        bst <= ddrmb_pkg::B_IDLE;
                        busy <= 1'b0;
                    end
                    else if (step)
                        beat <= beat + 2'h1;
                end
                default:
                begin
                    bst <= ddrmb_pkg::B_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
    assign burst_busy_o = busy;

    // column of each word of the pair, wrapped in its block
    assign c0 = {b_col[CW-1:3], (b_col[2:0] & ~b_mask) | ofs(b_col[2:0], {beat, 1'b0}, b_mask, b_intl)}; // RL21 RL24
    assign c1 = {b_col[CW-1:3], (b_col[2:0] & ~b_mask) | ofs(b_col[2:0], {beat, 1'b1}, b_mask, b_intl)}; // RL22 RL26
    assign idx0 = {b_bank, b_row, c0};
    assign idx1 = {b_bank, b_row, c1};

    // array: written only by write bursts
    assign mem_we = bst == ddrmb_pkg::B_WR && wr_valid_i; // RL16
    always_ff @(posedge core_clk_i)
    begin
        if (mem_we)
        begin
            mem[idx0] <= wr_rise_i; // RL2
            mem[idx1] <= wr_fall_i; // RL2
        end
    end
    assign f_in_data = {mem[idx0], mem[idx1]}; // RL4

    ddrmb_fifo #(
        .W(2 * DW),
        .DEPTH(FDEPTH)
    ) u_rd_fifo (
        .clk_i(core_clk_i),
        .rst_i(sys_rst_i),
        .in_valid_i(bst == ddrmb_pkg::B_RD),
        .in_data_i(f_in_data),
        .in_ready_o(f_in_ready),
        .out_valid_o(f_out_valid),
        .out_data_o(f_out_data),
        .out_ready_i(f_out_ready)
    );

    // read output stage
    assign f_out_ready = !rd_valid_o || rd_ready_i;
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rd_valid_o <= 1'b0;
            rd_rise_o <= '0;
            rd_fall_o <= '0;
            rd_strobe_o <= 1'b0;
        end
        else if (f_out_ready)
        begin
            rd_valid_o <= f_out_valid;
            if (f_out_valid)
            begin
                rd_rise_o <= f_out_data[2*DW-1:DW]; // RL2
                rd_fall_o <= f_out_data[DW-1:0]; // RL2
                rd_strobe_o <= !rd_strobe_o; // RL3
            end
        end
    end

    // presence-detect store over i2c
    logic [2:0] scl_s, sda_s, strap, cnt;
    logic scl_f, sda_f, scl_p, sda_p, scl_rise, scl_fall, start, stop;
    logic ack_ph, ack_go, rw, spd_we, sda_lo;
    logic [7:0] sh, ptr, tx, byte_in;
    logic [7:0] presence_detect_store [ddrmb_pkg::SPD_BYTES]; // RL11
    ddrmb_pkg::ddrmb_i2c_t i_st;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
            if (scl_s[1] == scl_s[2])
                scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2])
                sda_f <= sda_s[2];
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            strap <= presence_addr_straps_i;
        sda_lo <= 1'b0;
    end
    assign sda_o = sda_lo;

    assign scl_rise = scl_f && !scl_p;
    assign scl_fall = !scl_f && scl_p;
    assign start = scl_f && scl_p && sda_p && !sda_f;
    assign stop = scl_f && scl_p && !sda_p && sda_f;
    assign byte_in = {sh[6:0], sda_f};
    // upper half needs no guard; lower half stays writable too
    assign spd_we = scl_rise && i_st == ddrmb_pkg::I_WDAT && !ack_ph && cnt == 3'h7 &&
                    ddrmb_pkg::WP_LEVEL == 1'b0; // RL13

    always_ff @(posedge core_clk_i)
    begin
        if (spd_we)
            presence_detect_store[ptr] <= byte_in; // RL11
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            i_st <= ddrmb_pkg::I_IDLE;
            ack_ph <= 1'b0;
            ack_go <= 1'b0;
            rw <= 1'b0;
            cnt <= 3'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            tx <= 8'h00;
            sda_oe_o <= 1'b0;
        end
        else if (start)
        begin
            i_st <= ddrmb_pkg::I_ADDR;
            cnt <= 3'h0;
            ack_ph <= 1'b0;
        end
        else if (stop)
        begin
            i_st <= ddrmb_pkg::I_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (i_st != ddrmb_pkg::I_IDLE)
        begin
            if (scl_rise && !ack_ph)
            begin
                sh <= byte_in;
                cnt <= cnt + 3'h1;
                if (cnt == 3'h7)
                begin
                    ack_ph <= 1'b1;
                    ack_go <= 1'b0;
                    case (i_st)
                        ddrmb_pkg::I_ADDR:
                        begin
                            if (byte_in[7:1] == {ddrmb_pkg::SPD_DEV_TYPE, strap}) // RL12
                            begin
                                ack_go <= 1'b1;
                                rw <= byte_in[0];
                            end
                            else
                                i_st <= ddrmb_pkg::I_IDLE;
                        end
                        ddrmb_pkg::I_WADR:
                        begin
                            ptr <= byte_in;
                            ack_go <= 1'b1;
                        end
                        ddrmb_pkg::I_WDAT:
                        begin
                            ptr <= ptr + 8'h01;
                            ack_go <= 1'b1; // RL13
                        end
                        default:
                            ack_go <= 1'b0;
                    endcase
                end
            end
            else if (scl_rise)
            begin
                ack_ph <= 1'b0;
                case (i_st)
                    ddrmb_pkg::I_ADDR:
                    begin
                        if (rw)
                        begin
                            i_st <= ddrmb_pkg::I_RDAT;
                            tx <= presence_detect_store[ptr];
                            ptr <= ptr + 8'h01;
                        end
                        else
                            i_st <= ddrmb_pkg::I_WADR;
                    end
                    ddrmb_pkg::I_WADR:
                        i_st <= ddrmb_pkg::I_WDAT;
                    ddrmb_pkg::I_RDAT:
                    begin
                        if (sda_f)
                            i_st <= ddrmb_pkg::I_IDLE;
                        else
                        begin
                            tx <= presence_detect_store[ptr];
                            ptr <= ptr + 8'h01;
                        end
                    end
                    default:
                        i_st <= i_st;
                endcase
            end
            if (scl_fall)
            begin
                if (ack_ph)
                    sda_oe_o <= ack_go; // RL12
                else if (i_st == ddrmb_pkg::I_RDAT)
                    sda_oe_o <= !tx[~cnt];
                else
                    sda_oe_o <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_rd_cl2;
        rd_go && cl_code == ddrmb_pkg::CL_2;
    endsequence
    sequence s_rd_cl25;
        rd_go && cl_code != ddrmb_pkg::CL_2;
    endsequence
    sequence s_ap_end;
        burst_end && b_ap;
    endsequence

    a_mrs_load: assert property (mrs_go |=> mode == $past(addr_i)) // RL14
        else $error("mode register not loaded");
    a_dll_selfclr: assert property (mode[8] && !mrs_go |=> !mode[8] && mode[7:0] == $past(mode[7:0])) // RL15
        else $error("dll reset bit did not clear");
    a_act_open: assert property (act_go |=> bank_open_o[$past(ba_i)]) // RL6
        else $error("bank not opened by activate");
    a_rd_lat2: assert property (s_rd_cl2 |-> ##1 bst == ddrmb_pkg::B_LAT ##1 bst == ddrmb_pkg::B_RD) // RL25
        else $error("latency two not kept");
    a_rd_lat25: assert property (s_rd_cl25 |-> ##1 (bst == ddrmb_pkg::B_LAT) [*2] ##1 bst == ddrmb_pkg::B_RD) // RL25
        else $error("latency two and half not kept");
    a_fifo_hold: assert property (bst == ddrmb_pkg::B_RD && !f_in_ready |=> beat == $past(beat)) // RL4
        else $error("beat advanced while fifo full");
    a_wrap_block: assert property (!idle |-> (c0 & ~CW'(b_mask)) == (b_col & ~CW'(b_mask))) // RL22
        else $error("burst left its block");
    a_seq_order: assert property (!idle && !b_intl |-> c1[2:0] == (((c0[2:0] + 3'h1) & b_mask) | (c0[2:0] & ~b_mask))) // RL24
        else $error("sequential order broken");
    a_ap_close: assert property (s_ap_end |=> !bank_open_o[$past(b_bank)]) // RL9
        else $error("auto precharge missed");
    a_burst_len: assert property (burst_end |=> idle && !busy) // RL20
        else $error("burst ran past its length");
    a_mrs_nowrite: assert property (mrs_go && idle |=> idle) // RL16
        else $error("mode load wrote the array");
endmodule : ddrmb_core

module ddrmb_fifo #(
    parameter int W = 128,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] buf_q [DEPTH];
    logic [PW:0] wp, rp;

    assign in_ready_o = (wp - rp) != (PW + 1)'(DEPTH);
    assign out_valid_o = wp != rp;
    assign out_data_o = buf_q[rp[PW-1:0]];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (in_valid_i && in_ready_o)
                wp <= wp + (PW + 1)'(1);
            if (out_valid_o && out_ready_i)
                rp <= rp + (PW + 1)'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (in_valid_i && in_ready_o)
            buf_q[wp[PW-1:0]] <= in_data_i;
    end
endmodule : ddrmb_fifo
`default_nettype wire

//--- pkg/ddrmb_pkg.sv
// constants for the ddr mode and burst block
// assumes one core clock; command and data lanes come from logic on that clock
package ddrmb_pkg;
    // command code {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam int NBANK = 4;
    localparam int AP_BIT = 10;
    // mode register layout
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_DLL_BIT = 8;
    localparam logic [12:0] MR_RESET = 13'h0000;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] MASK_2 = 3'h1;
    localparam logic [2:0] MASK_4 = 3'h3;
    localparam logic [2:0] MASK_8 = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_25 = 3'h6;
    // 2.5 clocks rounds up to 3 whole core cycles
    localparam int CL2_CYC = 2;
    localparam int CL25_CYC = 3;
    // presence-detect store
    localparam int SPD_BYTES = 256;
    localparam int SPD_MAKER_BYTES = 128;
    localparam logic [3:0] SPD_DEV_TYPE = 4'hA;
    localparam logic WP_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        B_IDLE = 2'h0,
        B_LAT = 2'h1,
        B_RD = 2'h2,
        B_WR = 2'h3
    } ddrmb_bst_t;

    typedef enum logic [2:0] {
        I_IDLE = 3'h0,
        I_ADDR = 3'h1,
        I_WADR = 3'h2,
        I_WDAT = 3'h3,
        I_RDAT = 3'h4
    } ddrmb_i2c_t;
endpackage : ddrmb_pkg

//--- verif/ddrmb_reader.sv
// read-side consumer model for the ddr mode and burst block
// assumes the rd_* lanes of ddrmb_core on the same rising clock
`timescale 1ns/1ns
`default_nettype none
module ddrmb_reader (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic rd_valid_i,
    input wire logic [63:0] rd_rise_i,
    input wire logic [63:0] rd_fall_i,
    output logic rd_ready_o
);
    logic [63:0] q[$];
    initial rd_ready_o = 1'b0;
    // takes a pair on valid and ready, first word then second
    always @(posedge clk_i)
    begin
        if (rd_valid_i === 1'b1 && rd_ready_o === 1'b1)
        begin
            q.push_back(rd_rise_i);
            q.push_back(rd_fall_i);
        end
        rd_ready_o <= !stall_i;
    end
endmodule : ddrmb_reader
`default_nettype wire

//--- verif/tb.sv
// testbench for the ddr mode and burst block
// assumes ddrmb_core and the reader model; i2c lines idle with a pull-up
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cs_n = 1'b1;
    logic [2:0] cmd = 3'h7;
    logic [1:0] ba = 2'h0;
    logic [12:0] addr = 13'h0000;
    logic wr_valid = 1'b0;
    logic [63:0] wr_rise = 64'h0;
    logic [63:0] wr_fall = 64'h0;
    logic stall = 1'b0;
    logic rd_ready;
    logic rd_valid;
    logic rd_strobe;
    logic burst_busy;
    logic sda_o;
    logic sda_oe;
    logic [63:0] rd_rise;
    logic [63:0] rd_fall;
    logic [12:0] mode;
    logic [3:0] bank_open;
    logic sprev = 1'b0;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    wire logic sda_line = sda_m & !sda_oe;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int tgl = 0;
    localparam logic [2:0] BLC [3] = '{ddrmb_pkg::BL_8, ddrmb_pkg::BL_4, ddrmb_pkg::BL_2};
    localparam logic [2:0] CLC [3] = '{ddrmb_pkg::CL_2, ddrmb_pkg::CL_25, ddrmb_pkg::CL_2};
    localparam logic BTC [3] = '{1'b0, 1'b1, 1'b0};
    localparam logic [9:0] STC [3] = '{10'h005, 10'h006, 10'h007};

    always #25 core_clk_i = ~core_clk_i;

    ddrmb_core dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
        .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr), .wr_valid_i(wr_valid), .wr_rise_i(wr_rise),
        .wr_fall_i(wr_fall), .rd_ready_i(rd_ready), .rd_valid_o(rd_valid), .rd_rise_o(rd_rise),
        .rd_fall_o(rd_fall), .rd_strobe_o(rd_strobe), .mode_o(mode), .bank_open_o(bank_open),
        .burst_busy_o(burst_busy), .presence_addr_straps_i(3'h5), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe)
    );
    ddrmb_reader peer (
        .clk_i(core_clk_i), .stall_i(stall), .rd_valid_i(rd_valid), .rd_rise_i(rd_rise),
        .rd_fall_i(rd_fall), .rd_ready_o(rd_ready)
    );

    always @(posedge core_clk_i)
    begin
        if (rd_strobe !== sprev)
            tgl++;
        sprev = rd_strobe;
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            final_report();
        end
    end

    function automatic logic [9:0] col_at(input logic [9:0] st, input int j, input int len, input logic ilv);
        logic [9:0] m;
        m = 10'(len - 1);
        return (st & ~m) | ((ilv ? (st ^ 10'(j)) : (st + 10'(j))) & m);
    endfunction : col_at

    function automatic logic [63:0] dat(input logic [9:0] c);
        return 64'hD00 + {54'h0, c};
    endfunction : dat

    function automatic logic [12:0] mv(input logic [2:0] bl, input logic bt, input logic [2:0] cl, input logic dll);
        return {4'h0, dll, 1'b0, cl, bt, bl};
    endfunction : mv

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
        @(posedge core_clk_i);
        cs_n <= 1'b0;
        cmd <= c;
        ba <= b;
        addr <= a;
        @(posedge core_clk_i);
        cs_n <= 1'b1;
        cmd <= 3'h7;
    endtask : issue

    task automatic wait_idle();
        int i;
        i = 0;
        @(negedge core_clk_i);
        while (burst_busy === 1'b1 && i < 300)
        begin
            @(negedge core_clk_i);
            i++;
        end
        chk("burst_busy", 64'h0, {63'h0, burst_busy});
    endtask : wait_idle

    task automatic set_mode(input logic [12:0] v);
        logic seen;
        seen = 1'b0;
        issue(ddrmb_pkg::CMD_PRE, 2'h0, 13'h0400);
        issue(ddrmb_pkg::CMD_MRS, 2'h0, v);
        repeat (3)
        begin
            @(negedge core_clk_i);
            seen = seen | mode[8];
        end
        chk("dll_pulse", {63'h0, v[8]}, {63'h0, seen});
        chk("mode", {51'h0, v & 13'h1EFF}, {51'h0, mode});
    endtask : set_mode

    task automatic wr_burst(input logic [9:0] st, input int len, input logic ilv);
        issue(ddrmb_pkg::CMD_WR, 2'h1, {3'h0, st});
        for (int k = 0; k < len / 2; k++)
        begin
            wr_valid <= 1'b1;
            wr_rise <= dat(col_at(st, 2 * k, len, ilv));
            wr_fall <= dat(col_at(st, 2 * k + 1, len, ilv));
            @(posedge core_clk_i);
        end
        wr_valid <= 1'b0;
    endtask : wr_burst

    task automatic rd_expect(input logic [9:0] st, input int len, input logic ilv);
        int i;
        for (int j = 0; j < len; j++)
        begin
            i = 0;
            while (peer.q.size() == 0 && i < 400)
            begin
                @(negedge core_clk_i);
                i++;
            end
            chk("rd_word", dat(col_at(st, j, len, ilv)), peer.q.pop_front());
        end
    endtask : rd_expect

    task automatic hp();
        repeat (12) @(posedge core_clk_i);
    endtask : hp

    task automatic i2c_cond(input logic c);
        sda_m <= !c;
        hp();
        scl <= 1'b1;
        hp();
        sda_m <= c;
        hp();
        scl <= c;
        hp();
    endtask : i2c_cond

    task automatic i2c_byte(input logic [8:0] v, input logic [8:0] e);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--)
        begin
            sda_m <= v[i];
            hp();
            scl <= 1'b1;
            hp();
            r[i] = sda_line;
            scl <= 1'b0;
            hp();
        end
        chk("i2c_byte", {55'h0, e}, {55'h0, r});
    endtask : i2c_byte

    task automatic final_report();
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(negedge core_clk_i);
        chk("mode_rst", 64'h0, {51'h0, mode});
        chk("bank_rst", 64'h0, {60'h0, bank_open});
        set_mode(mv(ddrmb_pkg::BL_8, 1'b1, ddrmb_pkg::CL_2, 1'b1));
        issue(ddrmb_pkg::CMD_MRS, 2'h1, 13'h0002);
        @(negedge core_clk_i);
        chk("mode_ext", {51'h0, mv(ddrmb_pkg::BL_8, 1'b1, ddrmb_pkg::CL_2, 1'b0)}, {51'h0, mode});
        issue(ddrmb_pkg::CMD_ACT, 2'h1, 13'h0003);
        @(negedge core_clk_i);
        chk("bank_act", 64'h2, {60'h0, bank_open});
        wr_burst(10'h003, 8, 1'b1);
        wait_idle();
        for (int t = 0; t < 3; t++)
        begin
            set_mode(mv(BLC[t], BTC[t], CLC[t], 1'b0));
            issue(ddrmb_pkg::CMD_ACT, 2'h1, 13'h0003);
            tgl = 0;
            issue(ddrmb_pkg::CMD_RD, 2'h1, {2'h0, t == 2, STC[t]});
            if (t == 2)
                issue(ddrmb_pkg::CMD_ACT, 2'h0, 13'h0001);
            rd_expect(STC[t], 1 << BLC[t], BTC[t]);
            wait_idle();
            chk("strobe_tgl", 64'(1 << BLC[t]) / 2, 64'(tgl));
        end
        repeat (3) @(negedge core_clk_i);
        chk("bank_autopre", 64'h1, {60'h0, bank_open});
        issue(ddrmb_pkg::CMD_RD, 2'h1, 13'h0007);
        repeat (4) @(negedge core_clk_i);
        chk("closed_busy", 64'h0, {63'h0, burst_busy});
        chk("closed_data", 64'h0, 64'(peer.q.size()));
        set_mode(mv(ddrmb_pkg::BL_8, 1'b0, ddrmb_pkg::CL_2, 1'b0));
        issue(ddrmb_pkg::CMD_ACT, 2'h1, 13'h0003);
        @(posedge core_clk_i);
        stall <= 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            issue(ddrmb_pkg::CMD_RD, 2'h1, 13'h0000);
            wait_idle();
        end
        issue(ddrmb_pkg::CMD_RD, 2'h1, 13'h0000);
        repeat (20) @(negedge core_clk_i);
        chk("full_stall", 64'h1, {63'h0, burst_busy});
        @(posedge core_clk_i);
        stall <= 1'b0;
        for (int r = 0; r < 5; r++)
            rd_expect(10'h000, 8, 1'b0);
        wait_idle();
        chk("sda_o", 64'h0, {63'h0, sda_o});
        hp();
        i2c_cond(1'b0);
        i2c_byte(9'h155, 9'h154);
        i2c_byte(9'h101, 9'h100);
        i2c_byte(9'h0B5, 9'h0B4);
        i2c_cond(1'b1);
        i2c_cond(1'b0);
        i2c_byte(9'h155, 9'h154);
        i2c_byte(9'h101, 9'h100);
        i2c_cond(1'b0);
        i2c_byte(9'h157, 9'h156);
        i2c_byte(9'h1FF, 9'h0B5);
        i2c_cond(1'b1);
        final_report();
    end
endmodule : tb
`default_nettype wire
